// File: shared/usf_pkg.sv
// Summary of operation
// - Set rx timeout flag, status bit 11, when timeout lapses without line activity.
// - Rx timeout flag clears only by writing one to its clear bit.
// - Interrupt requested while rx timeout flag and its enable are both one.
// - Gap equal to timeout sets nothing; gap over timeout plus two samples sets flag.
// - Timeout counter runs with receiver off; flag sets only while receiver on.
// - In smartcard mode the timeout measures character or block waiting time.
// - Status bit 10 is the inverse of the clear-to-send input pin.
// - With flow control on, any toggle of that input sets change flag, bit 9.
// - LIN break detection sets break flag, bit 8; write-one clear; maskable interrupt.
// - Transmit-empty flag, bit 7, sets on shift load, clears on a data write unless a shift load comes in the same cycle.
// - Smartcard T=0 flush request sets transmit-empty and discards pending data.
// - Interrupt requested while transmit-empty flag and its enable are both one.
// - Features not built read their status bits as zero.
// - Receive data at 0x24 shows the character in bits 8:0, upper bits zero.
// - With parity on, the receive MSB read holds the received parity bit.
// - Transmit data at 0x28 takes the character in bits 8:0.
// - With parity on, written MSB is ignored and computed parity sent instead.
package usf_pkg;
	// ==========================================================
	// Register byte offsets
	localparam logic [7:0] USF_CTRL_ONE_OFF = 8'h00;
	localparam logic [7:0] USF_RTO_VAL_OFF = 8'h14;
	localparam logic [7:0] USF_REQ_OFF = 8'h18;
	localparam logic [7:0] USF_STAT_OFF = 8'h1C;
	localparam logic [7:0] USF_CLR_OFF = 8'h20;
	localparam logic [7:0] USF_RXD_OFF = 8'h24;
	localparam logic [7:0] USF_TXD_OFF = 8'h28;
	localparam logic [7:0] USF_EVT_OFF = 8'h2C;
	localparam logic [7:0] USF_MASK_OFF = 8'h30;
	// ==========================================================
	// Status, clear, enable and mask bit positions (shared layout)
	localparam int USF_B_RTO = 11;
	localparam int USF_B_CTS = 10;
	localparam int USF_B_FLOW_CHG = 9;
	localparam int USF_B_LBD = 8;
	localparam int USF_B_TX_EMPTY = 7;
	// Control-one bits
	localparam int USF_C_RX_ON = 0;
	localparam int USF_C_PAR_ON = 1;
	localparam int USF_C_NINE = 2;
	localparam int USF_C_OVS8 = 3;
	localparam int USF_C_FLOW_ON = 4;
	localparam int USF_C_SCARD = 5;
	localparam int USF_C_T0 = 6;
	// Request register bit
	localparam int USF_R_FLUSH = 0;
	// ==========================================================
	// Widths and timing
	localparam int USF_CHAR_W = 9;
	localparam int USF_RTO_W = 24;
	localparam int USF_SAMPLE_MARGIN = 2;
	localparam logic [31:0] USF_ZERO = 32'h0000_0000;
	localparam logic [11:0] USF_CTRL_RST = 12'h000;
endpackage : usf_pkg

// File: rtl/usf_sync.sv
`timescale 1ns/1ps
// Two-flop synchroniser for one level
module usf_sync (
	input wire logic clk, // Clock
	input wire logic rst_n, // Active-low reset
	input wire logic d, // Asynchronous level
	output logic q // Synchronised level
);
	logic meta_q;
	// ==========================================================
	// Only the second flop is read outside; resets to the idle-high level
	// of a low-active pin so that no false edge follows reset
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_q <= 1'b1;
			q <= 1'b1;
		end else begin
			meta_q <= d;
			q <= meta_q;
		end
	end
endmodule : usf_sync

// File: rtl/usf_rto.sv
`timescale 1ns/1ps
// Receiver-timeout counter in bit times, with sample-time margin
module usf_rto
	import usf_pkg::*;
#(
	parameter int CNT_W = usf_pkg::USF_RTO_W // Timeout width in bits
) (
	input wire logic clk, // Clock
	input wire logic rst_n, // Active-low reset
	input wire logic sample_tick, // One pulse per sample time
	input wire logic ovs8, // Eight samples per bit
	input wire logic activity, // Line activity restarts count
	input wire logic [CNT_W-1:0] limit, // Timeout in bit times
	output logic expired // Timeout plus margin passed
);
	// Refuse widths that the padded threshold arithmetic cannot hold
	if (CNT_W < 1 || CNT_W > 28) begin : g_bad_width
		$error("usf_rto: CNT_W out of range");
	end
	logic [CNT_W+4:0] cnt_q;
	logic [CNT_W+4:0] thr;
	logic [CNT_W+4:0] pad;
	// Threshold in samples: limit times oversampling plus margin
	assign pad = (CNT_W+5)'(USF_SAMPLE_MARGIN);
	assign thr = ovs8 ? ({2'b00, limit, 3'b000} + pad) :
		({1'b0, limit, 4'b0000} + pad);
	// Counts regardless of receiver state; saturates past threshold
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= '0;
		end else if (activity) begin
			cnt_q <= '0;
		end else if (sample_tick && cnt_q <= thr) begin
			cnt_q <= cnt_q + 1'b1;
		end
	end
	assign expired = (cnt_q > thr);
endmodule : usf_rto

// File: rtl/usf_top.sv
`timescale 1ns/1ps
// Status flags and data registers of the serial transceiver
module usf_top
	import usf_pkg::*;
#(
	parameter bit HAS_RTO = 1'b1, // Timeout feature built
	parameter bit HAS_FLOW = 1'b1, // Flow control built
	parameter bit HAS_LIN = 1'b1 // LIN break built
) (
	input wire logic clk_sys, // 25 MHz clock
	input wire logic rst_n, // Async active-low reset
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB direction
	input wire logic [7:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error
	input wire logic cts_n_pin, // Clear-to-send pin, low active
	input wire logic sample_tick, // Sample-time enable pulse
	input wire logic rx_activity, // Receive line activity pulse
	input wire logic lin_brk_det, // LIN break detected pulse
	input wire logic rx_char_valid, // Received character pulse
	input wire logic [usf_pkg::USF_CHAR_W-1:0] rx_char_in, // Received
	input wire logic tx_load_ack, // Shift register took data
	output logic tx_char_valid, // Pending character present
	output logic [usf_pkg::USF_CHAR_W-1:0] tx_char_out, // Char to shift
	output logic receiver_on, // Receiver enable
	output logic flow_control_on, // Flow control enable
	output logic irq // Level interrupt
);
	// ==========================================================
	// Reset release
	logic rst_s1_q;
	logic rst_s_n;
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rst_s1_q <= 1'b0;
			rst_s_n <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_s_n <= rst_s1_q;
		end
	end

	// ==========================================================
	// Bus decode: single-cycle answer, never wait states
	wire acc = psel && penable;
	wire wr = acc && pwrite;
	wire rd = acc && !pwrite;
	wire hit_ctrl = (paddr == USF_CTRL_ONE_OFF);
	wire hit_rto = (paddr == USF_RTO_VAL_OFF);
	wire hit_req = (paddr == USF_REQ_OFF);
	wire hit_stat = (paddr == USF_STAT_OFF);
	wire hit_clr = (paddr == USF_CLR_OFF);
	wire hit_rxd = (paddr == USF_RXD_OFF);
	wire hit_txd = (paddr == USF_TXD_OFF);
	wire hit_evt = (paddr == USF_EVT_OFF);
	wire hit_mask = (paddr == USF_MASK_OFF);
	wire mapped = hit_ctrl | hit_rto | hit_req | hit_stat | hit_clr |
		hit_rxd | hit_txd | hit_evt | hit_mask;
	assign pready = 1'b1;
	assign pslverr = acc && !mapped;

	// ==========================================================
	// Control registers
	logic [11:0] ctrl_q;
	logic [USF_RTO_W-1:0] rto_val_q;
	logic [31:0] mask_q;
	always_ff @(posedge clk_sys or negedge rst_s_n) begin
		if (!rst_s_n) begin
			ctrl_q <= USF_CTRL_RST;
			rto_val_q <= '0;
			mask_q <= USF_ZERO;
		end else begin
			if (wr && hit_ctrl) ctrl_q <= pwdata[11:0];
			if (wr && hit_rto) rto_val_q <= pwdata[USF_RTO_W-1:0];
			if (wr && hit_mask) mask_q <= pwdata;
		end
	end
	// Enable bits share the status layout inside control-one
	wire rx_timeout_irq_en = ctrl_q[USF_B_RTO];
	wire flow_change_irq_en = ctrl_q[USF_B_FLOW_CHG];
	wire lin_brk_irq_en = ctrl_q[USF_B_LBD];
	wire tx_empty_irq_en = ctrl_q[USF_B_TX_EMPTY];
	wire parity_on = ctrl_q[USF_C_PAR_ON];
	wire nine_bit = ctrl_q[USF_C_NINE];
	wire scard = ctrl_q[USF_C_SCARD];
	wire t0_mode = ctrl_q[USF_C_T0];
	assign receiver_on = ctrl_q[USF_C_RX_ON];
	assign flow_control_on = ctrl_q[USF_C_FLOW_ON] && HAS_FLOW;

	// ==========================================================
	// Clear-to-send input crossing
	logic cts_n_s;
	logic cts_n_d1_q;
	usf_sync u_cts_sync (
		.clk(clk_sys),
		.rst_n(rst_s_n),
		.d(cts_n_pin),
		.q(cts_n_s)
	);
	always_ff @(posedge clk_sys or negedge rst_s_n) begin
		if (!rst_s_n) cts_n_d1_q <= 1'b1;
		else cts_n_d1_q <= cts_n_s;
	end
	wire cts_level = HAS_FLOW && !cts_n_s;
	wire cts_toggle = (cts_n_s != cts_n_d1_q) && flow_control_on;

	// ==========================================================
	// Timeout: in smartcard mode the programmed value is the CWT/BWT,
	// counted the same way from the last character edge
	logic rto_expired;
	usf_rto #(
		.CNT_W(USF_RTO_W)
	) u_rto (
		.clk(clk_sys),
		.rst_n(rst_s_n),
		.sample_tick(sample_tick),
		.ovs8(ctrl_q[USF_C_OVS8]),
		.activity(rx_activity || (scard && rx_char_valid)),
		.limit(rto_val_q),
		.expired(rto_expired)
	);
	// Level gated by receiver enable so a lapsed count sets at once
	logic rto_seen_q;
	always_ff @(posedge clk_sys or negedge rst_s_n) begin
		if (!rst_s_n) rto_seen_q <= 1'b0;
		else if (!rto_expired) rto_seen_q <= 1'b0;
		else if (receiver_on) rto_seen_q <= 1'b1;
	end
	wire rto_set = HAS_RTO && rto_expired && receiver_on &&
		!rto_seen_q;

	// ==========================================================
	// Sticky flags; set wins over clear; status writes have no effect
	wire clr_wr = wr && hit_clr;
	logic rto_flag_q;
	logic flow_flag_q;
	logic brk_flag_q;
	always_ff @(posedge clk_sys or negedge rst_s_n) begin
		if (!rst_s_n) begin
			rto_flag_q <= 1'b0;
			flow_flag_q <= 1'b0;
			brk_flag_q <= 1'b0;
		end else begin
			if (rto_set) rto_flag_q <= 1'b1;
			else if (clr_wr && pwdata[USF_B_RTO]) rto_flag_q <= 1'b0;
			if (cts_toggle) flow_flag_q <= 1'b1;
			else if (clr_wr && pwdata[USF_B_FLOW_CHG]) flow_flag_q <= 1'b0;
			if (lin_brk_det && HAS_LIN) brk_flag_q <= 1'b1;
			else if (clr_wr && pwdata[USF_B_LBD]) brk_flag_q <= 1'b0;
		end
	end

	// ==========================================================
	// Transmit holding register and empty flag
	wire txd_wr = wr && hit_txd;
	wire flush = wr && hit_req && pwdata[USF_R_FLUSH] && scard && t0_mode;
	logic txe_q;
	logic [USF_CHAR_W-1:0] tx_hold_q;
	logic [USF_CHAR_W-1:0] tx_char_d;
	// Parity replaces the MSB: bit 8 in 9-bit frames, else bit 7
	function automatic logic [USF_CHAR_W-1:0] usf_par_fix(
		input logic [USF_CHAR_W-1:0] c, input logic nine, input logic pon);
		logic [USF_CHAR_W-1:0] r;
		r = c;
		if (pon && nine) r[8] = ^c[7:0];
		else if (pon) begin
			r[7] = ^c[6:0];
			r[8] = 1'b0;
		end
		return r;
	endfunction : usf_par_fix
	assign tx_char_d = usf_par_fix(pwdata[USF_CHAR_W-1:0], nine_bit,
		parity_on);
	// Write while full simply overwrites; software must wait for empty
	always_ff @(posedge clk_sys or negedge rst_s_n) begin
		if (!rst_s_n) begin
			txe_q <= 1'b1;
			tx_hold_q <= '0;
		end else begin
			if (txd_wr) tx_hold_q <= tx_char_d;
			if (flush || (tx_load_ack && !txe_q)) txe_q <= 1'b1;
			else if (txd_wr) txe_q <= 1'b0;
		end
	end
	assign tx_char_valid = !txe_q;
	assign tx_char_out = tx_hold_q;

	// ==========================================================
	// Receive data register; MSB holds received parity as delivered
	logic [USF_CHAR_W-1:0] rx_hold_q;
	always_ff @(posedge clk_sys or negedge rst_s_n) begin
		if (!rst_s_n) rx_hold_q <= '0;
		else if (rx_char_valid) rx_hold_q <= rx_char_in;
	end

	// ==========================================================
	// Status word and interrupt event register (cleared on read)
	logic [31:0] stat_w;
	always_comb begin
		stat_w = USF_ZERO;
		stat_w[USF_B_RTO] = rto_flag_q && HAS_RTO;
		stat_w[USF_B_CTS] = cts_level;
		stat_w[USF_B_FLOW_CHG] = flow_flag_q && HAS_FLOW;
		stat_w[USF_B_LBD] = brk_flag_q && HAS_LIN;
		stat_w[USF_B_TX_EMPTY] = txe_q;
	end
	logic [31:0] evt_q;
	logic [31:0] evt_set;
	always_comb begin
		evt_set = USF_ZERO;
		evt_set[USF_B_RTO] = rto_set;
		evt_set[USF_B_FLOW_CHG] = cts_toggle;
		evt_set[USF_B_LBD] = lin_brk_det && HAS_LIN;
		evt_set[USF_B_TX_EMPTY] = flush || (tx_load_ack && !txe_q);
	end
	wire evt_rd = rd && hit_evt;
	always_ff @(posedge clk_sys or negedge rst_s_n) begin
		if (!rst_s_n) evt_q <= USF_ZERO;
		else evt_q <= evt_set | (evt_rd ? USF_ZERO : evt_q);
	end

	// Flag interrupts gated by enables, event interrupts by mask
	wire flag_irq = (rto_flag_q && rx_timeout_irq_en) ||
		(flow_flag_q && flow_change_irq_en) ||
		(brk_flag_q && lin_brk_irq_en) ||
		(txe_q && tx_empty_irq_en);
	logic irq_q;
	always_ff @(posedge clk_sys or negedge rst_s_n) begin
		if (!rst_s_n) irq_q <= 1'b0;
		else irq_q <= flag_irq || |(evt_q & mask_q);
	end
	assign irq = irq_q;

	// ==========================================================
	// Read mux; status offset read-only, writes dropped
	logic [31:0] rdata_d;
	always_comb begin
		rdata_d = USF_ZERO;
		case (1'b1)
			hit_ctrl: rdata_d = {20'h00000, ctrl_q};
			hit_rto: rdata_d = {8'h00, rto_val_q};
			hit_stat: rdata_d = stat_w;
			hit_rxd: rdata_d = {23'h000000, rx_hold_q};
			hit_txd: rdata_d = {23'h000000, tx_hold_q};
			hit_evt: rdata_d = evt_q;
			hit_mask: rdata_d = mask_q;
			default: rdata_d = USF_ZERO;
		endcase
	end
	assign prdata = rd ? rdata_d : USF_ZERO;
endmodule : usf_top

// File: tb/usf_top_sva.sv
`timescale 1ns/1ps
// Checker on the bus, flag and transmit ports of the block
module usf_top_chk
	import usf_pkg::*;
#(
	parameter bit HAS_FLOW = 1'b1 // Flow control built
) (
	input wire logic clk_sys, // Clock
	input wire logic rst_n, // Reset
	input wire logic psel, // Select
	input wire logic penable, // Enable
	input wire logic pwrite, // Direction
	input wire logic [7:0] paddr, // Address
	input wire logic [31:0] pwdata, // Write data
	input wire logic [31:0] prdata, // Read data
	input wire logic pready, // Ready
	input wire logic pslverr, // Error
	input wire logic cts_n_pin, // Flow pin
	input wire logic tx_load_ack, // Shifter took data
	input wire logic tx_char_valid, // Pending char
	input wire logic receiver_on, // Receiver enable
	input wire logic flow_control_on // Flow enable
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);
	// ==========================================================
	// Access decodes
	wire logic acc = psel && penable;
	wire logic rd_st = acc && !pwrite && paddr == USF_STAT_OFF;
	wire logic rd_rx = acc && !pwrite && paddr == USF_RXD_OFF;
	wire logic wr_tx = acc && pwrite && paddr == USF_TXD_OFF;
	wire logic wr_cl = acc && pwrite && paddr == USF_CLR_OFF;
	wire logic wr_c1 = acc && pwrite && paddr == USF_CTRL_ONE_OFF;
	wire logic mapped = paddr inside {8'h00, 8'h14, 8'h18, 8'h1C, 8'h20,
		8'h24, 8'h28, 8'h2C, 8'h30};
	logic [31:0] seen_q;
	logic [2:0] up_q;
	// Flags once read as set may only drop through the clear register;
	// up_q hides the synchroniser's settling after reset
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			seen_q <= '0;
			up_q <= '0;
		end else begin
			up_q <= (up_q == 3'h7) ? up_q : up_q + 3'h1;
			if (rd_st)
				seen_q <= seen_q | (prdata & 32'h0000_0B00);
			else if (wr_cl)
				seen_q <= seen_q & ~pwdata;
		end
	end
	sequence s_tx_write;
		wr_tx && !tx_load_ack;
	endsequence
	sequence s_cts_steady;
		up_q == 3'h7 && $stable(cts_n_pin) &&
			$past(cts_n_pin, 2) == cts_n_pin && $past(cts_n_pin, 3) == cts_n_pin;
	endsequence
	property p_ready;
		acc |-> pready;
	endproperty
	property p_unmapped;
		acc && !mapped |-> pslverr && (pwrite || prdata == USF_ZERO);
	endproperty
	property p_tx_write;
		s_tx_write |=> tx_char_valid;
	endproperty
	property p_tx_load;
		tx_load_ack && tx_char_valid && !acc |=> !tx_char_valid;
	endproperty
	property p_txe_bit;
		rd_st |-> prdata[USF_B_TX_EMPTY] == !tx_char_valid;
	endproperty
	property p_cts;
		s_cts_steady ##0 rd_st |-> prdata[USF_B_CTS] == (HAS_FLOW && !cts_n_pin);
	endproperty
	property p_sticky;
		rd_st |-> (prdata & seen_q) == seen_q;
	endproperty
	property p_resv;
		rd_st |-> prdata[31:12] == 20'h00000 && prdata[6:0] == 7'h00;
	endproperty
	property p_rx_resv;
		rd_rx |-> prdata[31:9] == 23'h000000;
	endproperty
	property p_ctrl;
		wr_c1 |=> receiver_on == $past(pwdata[USF_C_RX_ON]) &&
			flow_control_on == (HAS_FLOW && $past(pwdata[USF_C_FLOW_ON]));
	endproperty
	a_ready: assert property (p_ready) else $error("wait state seen");
	a_unmapped: assert property (p_unmapped) else $error("unmapped not refused");
	a_tx_write: assert property (p_tx_write) else $error("tx not held");
	a_tx_load: assert property (p_tx_load) else $error("tx not empty");
	a_txe_bit: assert property (p_txe_bit) else $error("empty bit off");
	a_cts: assert property (p_cts) else $error("flow bit wrong");
	a_sticky: assert property (p_sticky) else $error("flag lost");
	a_resv: assert property (p_resv) else $error("status spare set");
	a_rx_resv: assert property (p_rx_resv) else $error("rx spare set");
	a_ctrl: assert property (p_ctrl) else $error("enable wrong");
endmodule : usf_top_chk
bind usf_top usf_top_chk #(.HAS_FLOW(HAS_FLOW)) usf_top_chk_i (
	.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .cts_n_pin(cts_n_pin),
	.tx_load_ack(tx_load_ack), .tx_char_valid(tx_char_valid),
	.receiver_on(receiver_on), .flow_control_on(flow_control_on));

// File: tb/usf_line_model.sv
`timescale 1ns/1ps
// Line side: sample ticks and a shifter that takes characters slowly
module usf_line_model (
	input wire logic clk_sys, // Clock
	input wire logic rst_n, // Reset
	input wire logic ack_en, // Shifter may take data
	input wire logic tx_char_valid, // Char waiting
	input wire logic [usf_pkg::USF_CHAR_W-1:0] tx_char_out, // Char
	output logic sample_tick, // Sample pulse
	output logic tx_load_ack, // Took char
	output logic [usf_pkg::USF_CHAR_W-1:0] last_tx // Last taken
);
	logic [1:0] wait_q;
	// Ticks every other cycle; a take waits four cycles, never two in a row
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			wait_q <= '0;
			tx_load_ack <= 1'b0;
			last_tx <= '0;
			sample_tick <= 1'b0;
		end else begin
			sample_tick <= !sample_tick;
			tx_load_ack <= 1'b0;
			if (tx_char_valid && ack_en && !tx_load_ack) begin
				wait_q <= wait_q + 2'h1;
				if (wait_q == 2'h3) begin
					tx_load_ack <= 1'b1;
					last_tx <= tx_char_out;
				end
			end
		end
	end
endmodule : usf_line_model

// File: tb/usf_top_bench.sv
`timescale 1ns/1ps
// Register-level bench of the flag and data block
module usf_top_bench;
	import usf_pkg::*;
	localparam logic [31:0] TXC [3] = '{32'h84, 32'h6, 32'h2};
	localparam logic [31:0] TXW [3] = '{32'h1A5, 32'h1FF, 32'h183};
	localparam logic [31:0] TX_EXP [3] = '{32'h1A5, 32'h0FF, 32'h003};
	logic clk_sys, rst_n, psel, penable, pwrite, pready, pslverr, cts_n_pin;
	logic sample_tick, tx_load_ack, tx_char_valid, irq, ack_en;
	logic receiver_on, flow_control_on;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [2:0] ev;
	logic [USF_CHAR_W-1:0] rx_char_in, tx_char_out, last_tx;
	int mismatches, total_checks, n, k;
	usf_top usf_top_i (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.cts_n_pin(cts_n_pin), .sample_tick(sample_tick),
		.rx_activity(ev[0]), .lin_brk_det(ev[1]), .rx_char_valid(ev[2]),
		.rx_char_in(rx_char_in), .tx_load_ack(tx_load_ack),
		.tx_char_valid(tx_char_valid), .tx_char_out(tx_char_out),
		.receiver_on(receiver_on), .flow_control_on(flow_control_on),
		.irq(irq));
	usf_line_model usf_line_model_i (.clk_sys(clk_sys), .rst_n(rst_n),
		.ack_en(ack_en), .tx_char_valid(tx_char_valid),
		.tx_char_out(tx_char_out), .sample_tick(sample_tick),
		.tx_load_ack(tx_load_ack), .last_tx(last_tx));
	// ==========================================================
	// Verdict, compare and bus tasks
	task results;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : results
	task check(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : check
	// Request held until ready is seen at an edge; a stuck bus ends the run
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		for (n = 0; n < 16; n++) begin
			@(posedge clk_sys);
			if (pready === 1'b1) break;
		end
		rd = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n == 16) begin
			mismatches++;
			results();
		end
	endtask : apb
	task rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		apb(1'b0, a, USF_ZERO);
		check(rd & m, e);
	endtask : rchk
	task pulse(input logic [2:0] m);
		@(posedge clk_sys);
		ev <= m;
		@(posedge clk_sys);
		ev <= 3'h0;
	endtask : pulse
	// Waits for t sample ticks as the design samples them; stuck ends run
	task ticks(input int t);
		k = 0;
		for (n = 0; n < 200 && k < t; n++) begin
			@(posedge clk_sys);
			if (sample_tick === 1'b1) k++;
		end
		if (k < t) begin
			mismatches++;
			results();
		end
	endtask : ticks
	task irq_is(input logic e);
		repeat (3) @(posedge clk_sys);
		check({31'h0, irq}, {31'h0, e});
	endtask : irq_is
	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end
	// ==========================================================
	// Main sequence
	initial begin
		{rst_n, psel, penable, pwrite, ack_en, ev} = '0;
		{paddr, pwdata, rx_char_in} = '0;
		cts_n_pin = 1'b1;
		mismatches = 0;
		total_checks = 0;
		repeat (8) @(posedge clk_sys);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk_sys);
		rchk(USF_STAT_OFF, 32'hFFFF_FFFF, 32'h80);
		rchk(8'h04, 32'hFFFF_FFFF, USF_ZERO);
		// Each format: stalled shifter, readback, then the character taken
		for (int i = 0; i < 3; i++) begin
			apb(1'b1, USF_CTRL_ONE_OFF, TXC[i]);
			irq_is(TXC[i][7]);
			rchk(USF_STAT_OFF, 32'h80, 32'h80);
			apb(1'b1, USF_TXD_OFF, TXW[i]);
			rchk(USF_STAT_OFF, 32'h80, USF_ZERO);
			irq_is(1'b0);
			rchk(USF_TXD_OFF, 32'h1FF, TX_EXP[i]);
			ack_en <= 1'b1;
			for (n = 0; n < 50 && tx_char_valid !== 1'b0; n++) @(posedge clk_sys);
			ack_en <= 1'b0;
			if (n == 50) begin
				mismatches++;
				results();
			end
			check({31'h0, tx_char_valid}, USF_ZERO);
			check({23'h0, last_tx}, TX_EXP[i]);
			rchk(USF_STAT_OFF, 32'h80, 32'h80);
		end
		// Flush is refused outside T=0, then empties the holding register
		apb(1'b1, USF_CTRL_ONE_OFF, 32'h20);
		apb(1'b1, USF_TXD_OFF, 32'h55);
		apb(1'b1, USF_REQ_OFF, 32'h1);
		rchk(USF_STAT_OFF, 32'h80, USF_ZERO);
		apb(1'b1, USF_CTRL_ONE_OFF, 32'h60);
		apb(1'b1, USF_REQ_OFF, 32'h1);
		rchk(USF_STAT_OFF, 32'h80, 32'h80);
		check({31'h0, tx_char_valid}, USF_ZERO);
		rx_char_in <= 9'h155;
		pulse(3'h4);
		rchk(USF_RXD_OFF, 32'hFFFF_FFFF, 32'h155);
		apb(1'b1, USF_CTRL_ONE_OFF, 32'h210);
		cts_n_pin <= 1'b0;
		repeat (6) @(posedge clk_sys);
		apb(1'b1, USF_STAT_OFF, USF_ZERO);
		rchk(USF_STAT_OFF, 32'h600, 32'h600);
		irq_is(1'b1);
		apb(1'b1, USF_CLR_OFF, 32'h200);
		rchk(USF_STAT_OFF, 32'h600, 32'h400);
		irq_is(1'b0);
		apb(1'b1, USF_CTRL_ONE_OFF, USF_ZERO);
		apb(1'b1, USF_MASK_OFF, 32'h100);
		apb(1'b0, USF_EVT_OFF, USF_ZERO);
		pulse(3'h2);
		irq_is(1'b1);
		rchk(USF_EVT_OFF, 32'h100, 32'h100);
		rchk(USF_EVT_OFF, 32'h100, USF_ZERO);
		rchk(USF_STAT_OFF, 32'h100, 32'h100);
		irq_is(1'b0);
		apb(1'b1, USF_CTRL_ONE_OFF, 32'h100);
		irq_is(1'b1);
		apb(1'b1, USF_CLR_OFF, 32'h100);
		irq_is(1'b0);
		// Timeout of one bit time, first with the receiver off
		apb(1'b1, USF_RTO_VAL_OFF, 32'h1);
		pulse(3'h1);
		repeat (60) @(posedge clk_sys);
		rchk(USF_STAT_OFF, 32'h800, USF_ZERO);
		apb(1'b1, USF_CTRL_ONE_OFF, 32'h801);
		rchk(USF_STAT_OFF, 32'h800, 32'h800);
		irq_is(1'b1);
		pulse(3'h1);
		apb(1'b1, USF_CLR_OFF, 32'h800);
		rchk(USF_STAT_OFF, 32'h800, USF_ZERO);
		irq_is(1'b0);
		// Ticks alternate, so the first read sees 18 ticks, the second 19
		pulse(3'h1);
		ticks(18);
		rchk(USF_STAT_OFF, 32'h800, USF_ZERO);
		rchk(USF_STAT_OFF, 32'h800, 32'h800);
		// Eight samples per bit: margin boundary at 10 ticks
		apb(1'b1, USF_CTRL_ONE_OFF, 32'h809);
		apb(1'b1, USF_CLR_OFF, 32'h800);
		pulse(3'h1);
		ticks(10);
		rchk(USF_STAT_OFF, 32'h800, USF_ZERO);
		rchk(USF_STAT_OFF, 32'h800, 32'h800);
		results();
	end
endmodule : usf_top_bench
